// ---- rtl/vsp_pkg.sv ----
package vsp_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] VSP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] VSP_EXT_OFS    = 8'h04;
  localparam logic [7:0] VSP_HTOT_OFS   = 8'h08;
  localparam logic [7:0] VSP_HSW_OFS    = 8'h0C;
  localparam logic [7:0] VSP_VTOT_OFS   = 8'h10;
  localparam logic [7:0] VSP_VSW_OFS    = 8'h14;
  localparam logic [7:0] VSP_PIX_OFS    = 8'h18;
  localparam logic [7:0] VSP_STAT_OFS   = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int VSP_CTRL_EN_BIT      = 0;
  localparam int VSP_CTRL_SRC_LSB     = 1;
  localparam int VSP_CTRL_SLAVE_BIT   = 3;
  localparam int VSP_EXT_LSB          = 16;
  localparam int VSP_EXT_HCOMP_BIT    = 16;
  localparam int VSP_EXT_HPOL_BIT     = 17;
  localparam int VSP_EXT_VCOMP_BIT    = 18;
  localparam int VSP_EXT_VPOL_BIT     = 19;
  localparam int VSP_PIX_COL_LSB      = 0;
  localparam int VSP_PIX_PAL_LSB      = 8;
  localparam int VSP_PIX_LCD_LSB      = 16;
  localparam int VSP_STAT_HACT_BIT    = 12;
  localparam int VSP_STAT_VACT_BIT    = 13;
  localparam int VSP_STAT_VCNT_LSB    = 16;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0]  VSP_CTRL_RST  = 4'h0;
  localparam logic [3:0]  VSP_EXT_RST   = 4'h0;
  localparam logic [11:0] VSP_HTOT_RST  = 12'h31F;
  localparam logic [7:0]  VSP_HSW_RST   = 8'h30;
  localparam logic [10:0] VSP_VTOT_RST  = 11'h20C;
  localparam logic [7:0]  VSP_VSW_RST   = 8'h02;
  localparam logic [23:0] VSP_PIX_RST   = 24'h000000;

  // ----------------------------------------------------------------
  // data source select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VSP_SRC_COLOUR,
    VSP_SRC_PALETTE,
    VSP_SRC_LCD,
    VSP_SRC_SPARE
  } vsp_src_t;

  // quarter-rate divider for lcd mode, in pixel ticks
  localparam logic [1:0] VSP_QDIV_LAST = 2'h3;

endpackage

// ---- rtl/vsp_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none
module vsp_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = ce ? async_in : meta_r;
    sync_nxt = ce ? meta_r : sync_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// ---- rtl/vsp_top.sv ----
// How it works
// R1 - enabled port drives qualifying clock with data
// R2 - qualifier at pixel rate, quarter in lcd
// R3 - data port selects colour, palette or lcd
// R4 - bits 17:16 pick hsync or nor composite, polarity
// R5 - line sync width counted in two-pixel units
// R6 - external sync input realigns video timing
// R7 - all video timing paced by video clock
// R8 - bits 19:18 pick vsync or xnor, width lines
// R9 - disabled port holds clock and data static
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module vsp_top
  import vsp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        video_clk,
  input  wire logic        ext_sync_in,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             ext_video_qual_clock,
  output logic [7:0]       ext_video_data
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;

  vsp_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in ({ext_sync_in, video_clk}),
    .sync_out (pin_sync)
  );

  logic vclk_d_r;
  logic vclk_d_nxt;
  logic esync_d_r;
  logic esync_d_nxt;
  logic pix_tick;
  logic esync_rise;

  always_comb begin
    vclk_d_nxt  = ce ? pin_sync[0] : vclk_d_r;
    esync_d_nxt = ce ? pin_sync[1] : esync_d_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vclk_d_r  <= 1'b0;
      esync_d_r <= 1'b0;
    end else begin
      vclk_d_r  <= vclk_d_nxt;
      esync_d_r <= esync_d_nxt;
    end
  end

  // one pixel per sampled rising edge of the video clock
  assign pix_tick   = ce & pin_sync[0] & ~vclk_d_r; // R7
  assign esync_rise = ce & pin_sync[1] & ~esync_d_r;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic [3:0]  ctrl_r;
  logic [3:0]  ctrl_nxt;
  logic [3:0]  ext_r;
  logic [3:0]  ext_nxt;
  logic [11:0] htot_r;
  logic [11:0] htot_nxt;
  logic [7:0]  hsw_r;
  logic [7:0]  hsw_nxt;
  logic [10:0] vtot_r;
  logic [10:0] vtot_nxt;
  logic [7:0]  vsw_r;
  logic [7:0]  vsw_nxt;
  logic [23:0] pix_r;
  logic [23:0] pix_nxt;
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rd_mux;
  logic        addr_ok;
  logic        h_act;
  logic        v_act;
  logic [11:0] hcnt_r;
  logic [10:0] vcnt_r;

  // the bus stalls while the block is frozen, so no transfer is lost
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign addr_ok   = hsel & htrans[1] & hready & ce;

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (haddr[7:0])
      VSP_CTRL_OFS: rd_mux[3:0] = ctrl_r;
      VSP_EXT_OFS:  rd_mux[VSP_EXT_LSB +: 4] = ext_r;
      VSP_HTOT_OFS: rd_mux[11:0] = htot_r;
      VSP_HSW_OFS:  rd_mux[7:0] = hsw_r;
      VSP_VTOT_OFS: rd_mux[10:0] = vtot_r;
      VSP_VSW_OFS:  rd_mux[7:0] = vsw_r;
      VSP_PIX_OFS:  rd_mux[23:0] = pix_r;
      VSP_STAT_OFS: begin
        rd_mux[11:0] = hcnt_r;
        rd_mux[VSP_STAT_HACT_BIT] = h_act;
        rd_mux[VSP_STAT_VACT_BIT] = v_act;
        rd_mux[VSP_STAT_VCNT_LSB +: 11] = vcnt_r;
      end
      default: rd_mux = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    ctrl_nxt    = ctrl_r;
    ext_nxt     = ext_r;
    htot_nxt    = htot_r;
    hsw_nxt     = hsw_r;
    vtot_nxt    = vtot_r;
    vsw_nxt     = vsw_r;
    pix_nxt     = pix_r;
    wr_pend_nxt = wr_pend_r;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt   = rdata_r;
    if (ce) begin
      if (wr_pend_r) begin
        unique case (wr_addr_r)
          VSP_CTRL_OFS: ctrl_nxt = hwdata[3:0];
          VSP_EXT_OFS:  ext_nxt  = hwdata[VSP_EXT_LSB +: 4];
          VSP_HTOT_OFS: htot_nxt = hwdata[11:0];
          VSP_HSW_OFS:  hsw_nxt  = hwdata[7:0];
          VSP_VTOT_OFS: vtot_nxt = hwdata[10:0];
          VSP_VSW_OFS:  vsw_nxt  = hwdata[7:0];
          VSP_PIX_OFS:  pix_nxt  = hwdata[23:0];
          default: ;
        endcase
      end
      wr_pend_nxt = addr_ok & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr_nxt = haddr[7:0];
      if (addr_ok & ~hwrite) begin
        rdata_nxt = rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= VSP_CTRL_RST;
      ext_r     <= VSP_EXT_RST;
      htot_r    <= VSP_HTOT_RST;
      hsw_r     <= VSP_HSW_RST;
      vtot_r    <= VSP_VTOT_RST;
      vsw_r     <= VSP_VSW_RST;
      pix_r     <= VSP_PIX_RST;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h00000000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      ext_r     <= ext_nxt;
      htot_r    <= htot_nxt;
      hsw_r     <= hsw_nxt;
      vtot_r    <= vtot_nxt;
      vsw_r     <= vsw_nxt;
      pix_r     <= pix_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // raster timing
  // ----------------------------------------------------------------
  logic [11:0] hcnt_nxt;
  logic [10:0] vcnt_nxt;
  logic [12:0] hsw_pix;
  logic        hs_comb;
  logic        vs_comb;
  logic        hsync_r;
  logic        hsync_nxt;
  logic        vsync_r;
  logic        vsync_nxt;

  assign hsw_pix = {4'h0, hsw_r, 1'b0};
  assign h_act   = {1'b0, hcnt_r} < hsw_pix; // R5
  assign v_act   = vcnt_r < {3'h0, vsw_r}; // R8

  always_comb begin
    hcnt_nxt = hcnt_r;
    vcnt_nxt = vcnt_r;
    if (ctrl_r[VSP_CTRL_SLAVE_BIT] && esync_rise) begin
      // slaved: restart the frame at the outside system's sync
      hcnt_nxt = 12'h000; // R6
      vcnt_nxt = 11'h000; // R6
    end else if (pix_tick) begin
      if (hcnt_r >= htot_r) begin
        hcnt_nxt = 12'h000;
        vcnt_nxt = (vcnt_r >= vtot_r) ? 11'h000 : vcnt_r + 11'h001;
      end else begin
        hcnt_nxt = hcnt_r + 12'h001;
      end
    end
  end

  always_comb begin
    // nor composite is active low by nature; polarity bit turns it round
    hs_comb = ext_r[VSP_EXT_HCOMP_BIT - VSP_EXT_LSB] ? ~(h_act | v_act) : h_act; // R4
    vs_comb = ext_r[VSP_EXT_VCOMP_BIT - VSP_EXT_LSB] ? ~(h_act ^ v_act) : v_act; // R8
    hsync_nxt = ce ? (hs_comb ^ ext_r[VSP_EXT_HPOL_BIT - VSP_EXT_LSB]) : hsync_r; // R4
    vsync_nxt = ce ? (vs_comb ^ ext_r[VSP_EXT_VPOL_BIT - VSP_EXT_LSB]) : vsync_r; // R8
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt_r  <= 12'h000;
      vcnt_r  <= 11'h000;
      hsync_r <= 1'b0;
      vsync_r <= 1'b0;
    end else begin
      hcnt_r  <= hcnt_nxt;
      vcnt_r  <= vcnt_nxt;
      hsync_r <= hsync_nxt;
      vsync_r <= vsync_nxt;
    end
  end

  assign hsync_out = hsync_r;
  assign vsync_out = vsync_r;

  // ----------------------------------------------------------------
  // digital video port
  // ----------------------------------------------------------------
  vsp_src_t    src;
  logic        port_en;
  logic        lcd_mode;
  logic [1:0]  qdiv_r;
  logic [1:0]  qdiv_nxt;
  logic        qual_r;
  logic        qual_nxt;
  logic [7:0]  data_r;
  logic [7:0]  data_nxt;
  logic [7:0]  src_data;
  logic        load;

  assign src      = vsp_src_t'(ctrl_r[VSP_CTRL_SRC_LSB +: 2]);
  assign port_en  = ctrl_r[VSP_CTRL_EN_BIT];
  assign lcd_mode = (src == VSP_SRC_LCD);

  always_comb begin
    unique case (src)
      VSP_SRC_COLOUR:  src_data = pix_r[VSP_PIX_COL_LSB +: 8]; // R3
      VSP_SRC_PALETTE: src_data = pix_r[VSP_PIX_PAL_LSB +: 8]; // R3
      VSP_SRC_LCD:     src_data = pix_r[VSP_PIX_LCD_LSB +: 8]; // R3
      VSP_SRC_SPARE:   src_data = 8'h00;
    endcase
  end

  // data changes as the qualifier falls (in lcd mode one clock before it falls), so its rise marks it valid
  assign load = pix_tick & (~lcd_mode | (qdiv_r == VSP_QDIV_LAST));

  always_comb begin
    qdiv_nxt = qdiv_r;
    qual_nxt = qual_r;
    data_nxt = data_r;
    // port state freezes with the rest of the block while ce is low
    if (ce && !port_en) begin
      qdiv_nxt = 2'h0; // R9
      qual_nxt = 1'b0; // R9
      data_nxt = 8'h00; // R9
    end else if (ce) begin
      if (pix_tick) begin
        qdiv_nxt = qdiv_r + 2'h1;
      end
      if (lcd_mode) begin
        qual_nxt = qdiv_r[1]; // R2
      end else begin
        // low for the first half of each pixel, high for the second
        qual_nxt = ~pin_sync[0]; // R2
      end
      if (load) begin
        data_nxt = src_data; // R1
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qdiv_r <= 2'h0;
      qual_r <= 1'b0;
      data_r <= 8'h00;
    end else begin
      qdiv_r <= qdiv_nxt;
      qual_r <= qual_nxt;
      data_r <= data_nxt;
    end
  end

  assign ext_video_qual_clock = qual_r; // R1
  assign ext_video_data       = data_r; // R1

endmodule
`default_nettype wire

// ---- verif/vsp_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module vsp_top_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        ext_video_qual_clock,
  input wire logic [7:0]  ext_video_data,
  input wire logic        vsync_out
);
  wire rd = hsel && htrans[1] && !hwrite && hready && ce;
  wire q  = ext_video_qual_clock;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // bus and port relations
  // ----------------------------------------------------------------
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_ready_ce: assert property (hreadyout == ce) else $error("hreadyout differs from ce");
  chk_rd_hold: assert property ($changed(hrdata) |-> $past(rd)) else $error("hrdata moved");
  chk_unmap_zero: assert property (rd && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_pad: assert property (rd && haddr == 32'h0 |=> hrdata[31:4] == 28'h0)
    else $error("control pad bits set");
  chk_stat_pad: assert property (rd && haddr == 32'h1C |=> (hrdata & 32'hF800C000) == 32'h0)
    else $error("status pad bits set");
  chk_qual_data: assert property ($rose(q) |-> $stable(ext_video_data))
    else $error("data moved at qualifier rise");
  // lcd high phase is two pixels, sixteen clocks, plus a short stall
  chk_qual_high: assert property ($rose(q) |-> ##[1:40] !q)
    else $error("qualifier stuck high");

  cover property ($rose(q));
  cover property ($rose(vsync_out));
  cover property (rd && haddr[31:8] != 24'h0);
endmodule
bind vsp_top vsp_top_chk u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .ext_video_qual_clock, .ext_video_data, .vsync_out);
`default_nettype wire

// ---- verif/vsp_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module vsp_far_end (
  input  wire logic       hclk,
  input  wire logic       clr,
  input  wire logic       qual,
  input  wire logic [7:0] data,
  input  wire logic       hs,
  input  wire logic       vs,
  output logic            video_clk,
  output logic [7:0]      cap,
  output logic [15:0]     qper,
  output logic [15:0]     hmin,
  output logic [15:0]     vmin
);
  logic [15:0] t = 16'h0;
  logic [15:0] tq, th, tv;
  logic        q1, h1, v1, hv, vv;

  // ----------------------------------------------------------------
  // pixel clock and panel-side capture
  // ----------------------------------------------------------------
  // pixel clock runs free, phase offset from hclk
  initial begin
    video_clk = 1'b0;
    #7;
    forever #160 video_clk = ~video_clk;
  end

  always @(posedge hclk) begin
    t  <= t + 16'h1;
    q1 <= qual;
    h1 <= hs;
    v1 <= vs;
    if (qual && !q1) begin
      cap  <= data;
      qper <= t - tq;
      tq   <= t;
    end
    if (hs && !h1) begin
      th <= t;
      hv <= 1'b1;
    end
    if (vs && !v1) begin
      tv <= t;
      vv <= 1'b1;
    end
    // shortest high run seen since the last clear
    if (!hs && h1 && hv && (t - th) < hmin) hmin <= t - th;
    if (!vs && v1 && vv && (t - tv) < vmin) vmin <= t - tv;
    if (clr) begin
      hv   <= 1'b0;
      vv   <= 1'b0;
      hmin <= 16'hFFFF;
      vmin <= 16'hFFFF;
      qper <= 16'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/video_sync_and_digital_port_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module video_sync_and_digital_port_test
  import vsp_pkg::*;
;
  localparam int P = 8;
  localparam int HT = 10;
  localparam int HW = 4;
  localparam int VT = 4;
  localparam int VW = 1;
  logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        ext_sync_in = 1'b0, clr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, video_clk, hsync_out, vsync_out, ext_video_qual_clock;
  logic [7:0]  ext_video_data, cap;
  logic [15:0] qper, hmin, vmin;
  int          fail_count = 0, n_tests = 0, cyc = 0;

  vsp_top DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .video_clk, .ext_sync_in, .hsync_out,
    .vsync_out, .ext_video_qual_clock, .ext_video_data);
  vsp_far_end u_far (.hclk, .clr, .qual(ext_video_qual_clock), .data(ext_video_data),
    .hs(hsync_out), .vs(vsync_out), .video_clk, .cap, .qper, .hmin, .vmin);

  // ----------------------------------------------------------------
  // clock, watchdog, bus tasks
  // ----------------------------------------------------------------
  initial begin
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task summarize;
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, {24'h0, a}, d);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, {24'h0, a}, 32'h0);
  endtask

  task settle(input int n);
    // let the step from the mode switch reach the far end before it clears
    @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (n) @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rstv [7];
    logic [31:0] msk [7];
    int          hexp [4];
    int          vexp [4];
    logic [7:0]  pexp [4];
    rstv = '{{28'h0, VSP_CTRL_RST}, {12'h0, VSP_EXT_RST, 16'h0}, {20'h0, VSP_HTOT_RST},
      {24'h0, VSP_HSW_RST}, {21'h0, VSP_VTOT_RST}, {24'h0, VSP_VSW_RST}, {8'h0, VSP_PIX_RST}};
    msk = '{32'hF, 32'hF0000, 32'hFFF, 32'hFF, 32'h7FF, 32'hFF, 32'hFFFFFF};
    hexp = '{HW * P, (HT - HW) * P, (HT - HW) * P, HW * P};
    vexp = '{VW * HT * P, (HT - HW) * P, (VT - VW) * HT * P, HW * P};
    pexp = '{8'hAB, 8'h5A, 8'h3C, 8'h00};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(r, rstv[i]);
      wr(8'(4 * i), 32'hFFFFFFFF);
      rd(8'(4 * i));
      chk(r, msk[i]);
    end
    wr(VSP_STAT_OFS, 32'hFFFFFFFF);
    rd(VSP_STAT_OFS);
    chk(r & 32'hF800C000, 32'h0);
    xfer(1'b0, 32'h100, 32'h0);
    chk(r, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20);
    chk(r, 32'h0);
    ce <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(hreadyout, 32'h0);
    ce <= 1'b1;
    wr(VSP_CTRL_OFS, 32'h0);
    wr(VSP_HTOT_OFS, 32'(HT - 1));
    wr(VSP_HSW_OFS, 32'(HW / 2));
    wr(VSP_VTOT_OFS, 32'(VT - 1));
    wr(VSP_VSW_OFS, 32'(VW));
    wr(VSP_PIX_OFS, 32'h3C5AAB);
    for (int k = 0; k < 4; k++) begin
      wr(VSP_EXT_OFS, (32'(k) << VSP_EXT_HCOMP_BIT) | (32'(k) << VSP_EXT_VCOMP_BIT));
      settle(800);
      chk(32'(hmin), hexp[k]);
      chk(32'(vmin), vexp[k]);
    end
    wr(VSP_EXT_OFS, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(VSP_CTRL_OFS, (32'(s) << VSP_CTRL_SRC_LSB) | 32'h1);
      settle(100);
      chk(32'(cap), 32'(pexp[s]));
      chk(32'(qper), (s == 2) ? 4 * P : P);
    end
    wr(VSP_CTRL_OFS, 32'h0);
    settle(40);
    chk(32'(ext_video_data), 32'h0);
    chk(32'(qper), 32'h0);
    for (int m = 0; m < 2; m++) begin
      wr(VSP_CTRL_OFS, 32'(m) << VSP_CTRL_SLAVE_BIT);
      while (vsync_out !== 1'b1) @(posedge hclk);
      while (vsync_out !== 1'b0) @(posedge hclk);
      ext_sync_in <= 1'b1;
      repeat (3) @(posedge hclk);
      ext_sync_in <= 1'b0;
      repeat (5) @(posedge hclk);
      chk(32'(vsync_out), 32'(m));
    end
    summarize();
  end
endmodule
`default_nettype wire
